/* File: hdl/pulse_port_pkg.sv */
// Shared constants and types of the pulse counter port logic
package pulse_port_pkg;

   // Bus address layout
   localparam int PORT_LSB = 12;
   localparam int STATUS_BIT = 15;
   localparam logic [2:0] PORT_DISPLAY = 3'h0;
   localparam logic [2:0] PORT_INTERVAL = 3'h1;
   localparam logic [2:0] PORT_CONTROL = 3'h2;
   localparam logic [2:0] PORT_SWITCH = 3'h3;

   // Channel control strobe codes
   localparam logic [2:0] CTRL_CLEAR_A = 3'h0;
   localparam logic [2:0] CTRL_START_A = 3'h1;
   localparam logic [2:0] CTRL_CLEAR_B = 3'h2;
   localparam logic [2:0] CTRL_START_B = 3'h3;

   // Interval counter registers
   localparam logic [1:0] IC_COUNT_A = 2'h0;
   localparam logic [1:0] IC_COUNT_B = 2'h1;
   localparam logic [1:0] IC_TIMEBASE = 2'h2;
   localparam logic [1:0] IC_CONTROL = 2'h3;
   localparam logic [7:0] IC_COUNT_RST = 8'h00;
   localparam logic [7:0] IC_TIMEBASE_RST = 8'hFF;
   localparam logic [7:0] IC_CONTROL_RST = 8'h01;
   localparam int IC_RUN_BIT = 0;

   // Parallel input port registers
   localparam logic [1:0] PIO_LOW = 2'h0;
   localparam logic [1:0] PIO_MID = 2'h1;
   localparam logic [1:0] PIO_HIGH = 2'h2;
   localparam logic [7:0] PIO_MODE_ALL_IN = 8'hFF;

   // Status and switch byte fields
   localparam int STAT_EN_A = 0;
   localparam int STAT_EN_B = 1;
   localparam int STAT_RATE_A = 2;
   localparam int STAT_RATE_B = 3;
   localparam int SW_INC = 0;
   localparam int SW_DEC = 1;
   localparam int SW_SEL = 2;
   localparam int SW_ROT_LSB = 3;
   localparam int SW_EXC = 7;

   // Display access settle time
   localparam int CLK_PERIOD_PS = 5000;
   localparam int DISPLAY_SETTLE_NS = 20;
   localparam int DISPLAY_WAIT_CYC = (DISPLAY_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEL = 3'b010,
      ST_ACK = 3'b100
   } bus_state_t;

endpackage : pulse_port_pkg

/* File: hdl/sync2.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_regs_t;

   sync_regs_t q;
   sync_regs_t d;

   // First stage feeds only the second
   always_comb begin
      d.meta = async_in;
      d.sync = q.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_q = q.sync;

endmodule : sync2

/* File: hdl/pulse_channel.sv */
// Two cascaded counter stages of one pulse channel
`timescale 1ns/1ps
module pulse_channel #(
   parameter int STAGE_W = 12
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Count control
   input wire logic step,
   input wire logic clear,
   output logic [2*STAGE_W-1:0] count_q
);

   typedef struct packed {
      logic [STAGE_W-1:0] hi;
      logic [STAGE_W-1:0] lo;
   } chan_regs_t;

   chan_regs_t q;
   chan_regs_t d;

   always_comb begin
      d = q;
      if (clear) begin
         d = '0;
      end else if (step) begin
         d.lo = q.lo + STAGE_W'(1);
         // Carry on falling top bit of first stage
         if (q.lo[STAGE_W-1] && !d.lo[STAGE_W-1]) begin // R18
            d.hi = q.hi + STAGE_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count_q = {q.hi, q.lo};

   cascade_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R18
      step && !clear && (&q.lo) |=> q.lo == '0 && q.hi == $past(q.hi) + STAGE_W'(1))
      else $error("second stage missed carry on wrap");

endmodule : pulse_channel

/* File: hdl/pulse_counter_port_logic.sv */
// Port decode, control latches and counters of the four-channel pulse input board
//
// Summary of operation
// R1 - Port select low decodes one of eight selects
// R2 - Code 000 reaches display registers by A05-A00
// R3 - Code 001 reaches interval counters and control
// R4 - Code 010 yields exactly one control strobe
// R5 - Clear zeros pair counters, start enables counting
// R6 - Code 011 reads buttons, rotary, excitation status
// R7 - Codes 100-111 reach per-channel input ports
// R8 - Port reads give both counter stages bytewise
// R9 - Status reads count-enable and rate bits per pair
// R10 - Processor ignores count-enable in accumulate mode
// R11 - Inverted pulse: trailing edge advances count
// R12 - Rate mode: count-enable gates both pair channels
// R13 - Rate mode: clear resets all pair counters
// R14 - Load interval, clear, then start sets latch
// R15 - Interval expiry clears latch, count-enable low
// R16 - Processor reads counts after count-enable drops
// R17 - Accumulate: rate bit low, clear disabled, ungated
// R18 - First stage wrap increments second stage
// R19 - Processor reads running totals without clearing
// R20 - Processor programs interval from tuning parameters
// R21 - One mode switch per pair selects operation
// R22 - Selects idle when deselected; strobes one access
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pulse_counter_port_logic #(
   parameter int STAGE_W = 12
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Avalon-MM slave
   input wire logic [15:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [7:0] writedata,
   output logic [7:0] readdata,
   output logic waitrequest,
   // Field pulses and front panel
   input wire logic [3:0] pulse_in,
   input wire logic pair_a_mode_switch,
   input wire logic pair_b_mode_switch,
   input wire logic increment_button,
   input wire logic decrement_button,
   input wire logic select_button,
   input wire logic [3:0] rotary_selector,
   input wire logic excitation_ok,
   // Display device
   input wire logic [7:0] display_rdata,
   output logic port_select_n,
   output logic [7:0] chip_select_n,
   output logic [5:0] io_addr,
   output logic [7:0] io_wdata,
   output logic io_write,
   output logic io_read,
   // Pair count enables
   output logic pair_a_count_enable,
   output logic pair_b_count_enable
);

   typedef struct packed {
      pulse_port_pkg::bus_state_t state;
      logic [2:0] wait_cnt;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic is_write;
      logic waitreq;
      logic [7:0] rdata;
      logic port_sel_n;
      logic [7:0] cs_n;
      logic io_we;
      logic io_re;
      logic [1:0] en;
      logic [1:0] clr;
      logic [1:0] start;
      logic [7:0] ic_cnt_a;
      logic [7:0] ic_cnt_b;
      logic [7:0] ic_tb;
      logic [7:0] ic_ctrl;
      logic [7:0] tick_cnt;
      logic [3:0] pulse_prev;
   } regs_t;

   localparam regs_t REGS_RST = '{
      state: pulse_port_pkg::ST_IDLE,
      wait_cnt: 3'h0,
      addr: 16'h0000,
      wdata: 8'h00,
      is_write: 1'b0,
      waitreq: 1'b1,
      rdata: 8'h00,
      port_sel_n: 1'b1,
      cs_n: 8'hFF,
      io_we: 1'b0,
      io_re: 1'b0,
      en: 2'h0,
      clr: 2'h0,
      start: 2'h0,
      ic_cnt_a: pulse_port_pkg::IC_COUNT_RST,
      ic_cnt_b: pulse_port_pkg::IC_COUNT_RST,
      ic_tb: pulse_port_pkg::IC_TIMEBASE_RST,
      ic_ctrl: pulse_port_pkg::IC_CONTROL_RST,
      tick_cnt: pulse_port_pkg::IC_TIMEBASE_RST,
      pulse_prev: 4'h0
   };

   regs_t q;
   regs_t d;

   logic [3:0] pulse_s;
   logic [1:0] rate_s;
   logic [2:0] button_s;
   logic [3:0] rotary_s;
   logic exc_s;
   logic [7:0] disp_s;
   logic [3:0] step;
   logic [3:0] chan_clear;
   logic [2*STAGE_W-1:0] count [4];
   logic tick;
   logic req_go;
   logic is_display;
   localparam logic [2:0] DISP_LAST = 3'(pulse_port_pkg::DISPLAY_WAIT_CYC - 1);

   function automatic logic [7:0] count_byte(input logic [2*STAGE_W-1:0] cnt,
                                             input logic [1:0] sel);
      logic [23:0] wide;
      wide = 24'(cnt);
      unique case (sel)
         pulse_port_pkg::PIO_LOW: count_byte = wide[7:0];
         pulse_port_pkg::PIO_MID: count_byte = wide[15:8];
         pulse_port_pkg::PIO_HIGH: count_byte = wide[23:16];
         default: count_byte = pulse_port_pkg::PIO_MODE_ALL_IN;
      endcase
   endfunction : count_byte

   function automatic logic [2:0] port_code(input logic [15:0] a);
      port_code = a[pulse_port_pkg::PORT_LSB +: 3];
   endfunction : port_code

   // All pins pass two flops before use
   sync2 #(
      .WIDTH(22)
   ) pin_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in({pulse_in, pair_b_mode_switch, pair_a_mode_switch,
                 select_button, decrement_button, increment_button,
                 rotary_selector, excitation_ok, display_rdata}),
      .sync_q({pulse_s, rate_s, button_s, rotary_s, exc_s, disp_s})
   );

   // Trailing edge counts; rate mode gates by pair enable
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         step[i] = q.pulse_prev[i] && !pulse_s[i] // R11
                   && (!rate_s[i/2] || q.en[i/2]); // R12 R17
         chan_clear[i] = q.clr[i/2] && rate_s[i/2]; // R5 R13 R17
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_chan
      pulse_channel #(
         .STAGE_W(STAGE_W)
      ) chan (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .step(step[g]),
         .clear(chan_clear[g]),
         .count_q(count[g])
      );
   end

   assign tick = q.ic_ctrl[pulse_port_pkg::IC_RUN_BIT] && q.tick_cnt == 8'h00;
   assign req_go = q.state == pulse_port_pkg::ST_IDLE && (read || write);
   assign is_display = !q.addr[pulse_port_pkg::STATUS_BIT]
                       && port_code(q.addr) == pulse_port_pkg::PORT_DISPLAY;

   always_comb begin
      d = q;
      d.clr = 2'h0;
      d.start = 2'h0;
      d.pulse_prev = pulse_s;

      // Shared timebase for the interval counters
      if (!q.ic_ctrl[pulse_port_pkg::IC_RUN_BIT] || tick) begin
         d.tick_cnt = q.ic_tb;
      end else begin
         d.tick_cnt = q.tick_cnt - 8'h01;
      end

      // Interval runs only while the latch is set
      if (q.en[0] && tick && q.ic_cnt_a != 8'h00) begin // R15
         d.ic_cnt_a = q.ic_cnt_a - 8'h01;
      end
      if (q.en[1] && tick && q.ic_cnt_b != 8'h00) begin // R15
         d.ic_cnt_b = q.ic_cnt_b - 8'h01;
      end
      // Expiry clears the latch; a start in the same cycle wins
      if (q.en[0] && q.ic_cnt_a == 8'h00) begin
         d.en[0] = 1'b0; // R15
      end
      if (q.en[1] && q.ic_cnt_b == 8'h00) begin
         d.en[1] = 1'b0; // R15
      end
      if (q.start[0]) begin
         d.en[0] = 1'b1; // R5 R14
      end
      if (q.start[1]) begin
         d.en[1] = 1'b1; // R5 R14
      end

      unique case (q.state)
         pulse_port_pkg::ST_IDLE: begin
            d.waitreq = 1'b1;
            if (req_go) begin
               d.state = pulse_port_pkg::ST_SEL;
               d.addr = address;
               d.wdata = writedata;
               d.is_write = write;
               d.wait_cnt = 3'h0;
               // Status port lives outside the select decode
               if (!address[pulse_port_pkg::STATUS_BIT]) begin
                  d.port_sel_n = 1'b0;
                  d.cs_n = ~(8'h01 << port_code(address)); // R1
                  d.io_we = write;
                  d.io_re = read;
               end
            end
         end
         pulse_port_pkg::ST_SEL: begin
            // Display data crosses two flops; keep it selected until settled
            if (is_display && q.wait_cnt != DISP_LAST) begin
               d.wait_cnt = q.wait_cnt + 3'h1;
            end else begin
               d.state = pulse_port_pkg::ST_ACK;
               d.waitreq = 1'b0;
               d.port_sel_n = 1'b1; // R22
               d.cs_n = 8'hFF; // R22
               d.io_we = 1'b0;
               d.io_re = 1'b0;
               d.rdata = 8'h00;
               if (q.addr[pulse_port_pkg::STATUS_BIT]) begin
                  d.rdata[pulse_port_pkg::STAT_EN_A] = q.en[0]; // R9
                  d.rdata[pulse_port_pkg::STAT_EN_B] = q.en[1]; // R9
                  d.rdata[pulse_port_pkg::STAT_RATE_A] = rate_s[0]; // R9 R17 R21
                  d.rdata[pulse_port_pkg::STAT_RATE_B] = rate_s[1]; // R9 R17 R21
               end else begin
                  unique case (port_code(q.addr))
                     pulse_port_pkg::PORT_DISPLAY: begin
                        d.rdata = disp_s; // R2
                     end
                     pulse_port_pkg::PORT_INTERVAL: begin
                        unique case (q.addr[1:0])
                           pulse_port_pkg::IC_COUNT_A: begin
                              d.rdata = q.ic_cnt_a; // R3
                              if (q.is_write) begin
                                 d.ic_cnt_a = q.wdata; // R3
                              end
                           end
                           pulse_port_pkg::IC_COUNT_B: begin
                              d.rdata = q.ic_cnt_b; // R3
                              if (q.is_write) begin
                                 d.ic_cnt_b = q.wdata; // R3
                              end
                           end
                           pulse_port_pkg::IC_TIMEBASE: begin
                              d.rdata = q.ic_tb; // R3
                              if (q.is_write) begin
                                 d.ic_tb = q.wdata; // R3
                              end
                           end
                           pulse_port_pkg::IC_CONTROL: begin
                              d.rdata = q.ic_ctrl; // R3
                              if (q.is_write) begin
                                 d.ic_ctrl = q.wdata; // R3
                              end
                           end
                        endcase
                     end
                     pulse_port_pkg::PORT_CONTROL: begin
                        // Any access to codes 0-3 fires its one strobe, read or write
                        if (q.addr[2:0] == pulse_port_pkg::CTRL_CLEAR_A) begin
                           d.clr[0] = 1'b1; // R4 R5 R13
                        end
                        if (q.addr[2:0] == pulse_port_pkg::CTRL_START_A) begin
                           d.start[0] = 1'b1; // R4 R5 R14
                        end
                        if (q.addr[2:0] == pulse_port_pkg::CTRL_CLEAR_B) begin
                           d.clr[1] = 1'b1; // R4 R5 R13
                        end
                        if (q.addr[2:0] == pulse_port_pkg::CTRL_START_B) begin
                           d.start[1] = 1'b1; // R4 R5 R14
                        end
                     end
                     pulse_port_pkg::PORT_SWITCH: begin
                        d.rdata[pulse_port_pkg::SW_INC] = button_s[0]; // R6
                        d.rdata[pulse_port_pkg::SW_DEC] = button_s[1]; // R6
                        d.rdata[pulse_port_pkg::SW_SEL] = button_s[2]; // R6
                        d.rdata[pulse_port_pkg::SW_ROT_LSB +: 4] = rotary_s; // R6
                        d.rdata[pulse_port_pkg::SW_EXC] = exc_s; // R6
                     end
                     default: begin
                        d.rdata = count_byte(count[q.addr[pulse_port_pkg::PORT_LSB +: 2]],
                                             q.addr[1:0]); // R7 R8
                     end
                  endcase
               end
            end
         end
         pulse_port_pkg::ST_ACK: begin
            // Answer stands one cycle; the master releases at its edge
            d.state = pulse_port_pkg::ST_IDLE;
            d.waitreq = 1'b1;
         end
         default: begin
            d = REGS_RST;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   assign readdata = q.rdata;
   assign waitrequest = q.waitreq;
   assign port_select_n = q.port_sel_n;
   assign chip_select_n = q.cs_n;
   assign io_addr = q.addr[5:0];
   assign io_wdata = q.wdata;
   assign io_write = q.io_we;
   assign io_read = q.io_re;
   assign pair_a_count_enable = q.en[0];
   assign pair_b_count_enable = q.en[1];

   sequence answer_s;
      q.state == pulse_port_pkg::ST_ACK && !q.waitreq;
   endsequence
   sequence released_s;
      q.state == pulse_port_pkg::ST_IDLE && q.waitreq;
   endsequence
   bus_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
      answer_s |=> released_s)
      else $error("answer did not release the bus");
   select_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
      q.port_sel_n |-> q.cs_n == 8'hFF)
      else $error("chip select active while deselected");
   one_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
      !q.port_sel_n |-> $onehot(~q.cs_n))
      else $error("not exactly one chip select");
   strobe_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
      ((|q.clr) || (|q.start)) |=> q.clr == 2'h0 && q.start == 2'h0)
      else $error("control strobe longer than one cycle");
   start_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
      q.start[1] |=> q.en[1])
      else $error("start strobe did not set the latch");
   expiry_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
      q.en[1] && q.ic_cnt_b == 8'h00 && !q.start[1] |=> !q.en[1])
      else $error("interval expiry left the latch set");
   rate_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
      rate_s[1] && !q.en[1] |-> step[3:2] == 2'h0)
      else $error("pulse counted with the pair gate closed");

endmodule : pulse_counter_port_logic

/* File: tb/display_model.sv */
// Display device model answering reads on the io bus
`timescale 1ns/1ps
module display_model (
   // Clock
   input wire logic ref_clk,
   // Io bus
   input wire logic [7:0] chip_select_n,
   input wire logic [5:0] io_addr,
   input wire logic io_read,
   output logic [7:0] display_rdata
);
   logic [7:0] idle_q = 8'h3C;
   // Released bus shows a changing pattern, never a stale value
   always_ff @(posedge ref_clk) begin
      idle_q <= ~idle_q;
   end
   always_comb begin
      if (!chip_select_n[0] && io_read) begin
         display_rdata = {2'h0, io_addr} ^ 8'hA5;
      end else begin
         display_rdata = idle_q;
      end
   end
endmodule : display_model

/* File: tb/pulse_counter_port_logic_bench.sv */
// Self-checking bench of the pulse counter port logic
`timescale 1ns/1ps
module pulse_counter_port_logic_bench;
   logic ref_clk = 0, rst_b = 0, read = 0, write = 0, waitrequest, port_select_n;
   logic [15:0] address = 16'h0000;
   logic [7:0] writedata = 8'h00, readdata, display_rdata, chip_select_n, io_wdata, rd;
   logic [3:0] pulse_in = 4'h0, rotary_selector = 4'h0;
   logic pair_a_mode_switch = 0, pair_b_mode_switch = 0, excitation_ok = 0;
   logic increment_button = 0, decrement_button = 0, select_button = 0;
   logic io_write, io_read, pair_a_count_enable, pair_b_count_enable;
   logic [5:0] io_addr;
   int errors = 0, checked = 0, seed = 32'h7EF9, cnt[4] = '{0, 0, 0, 0};
   always #2.5 ref_clk = ~ref_clk;
   pulse_counter_port_logic #(.STAGE_W(12)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .pulse_in(pulse_in),
      .pair_a_mode_switch(pair_a_mode_switch), .pair_b_mode_switch(pair_b_mode_switch),
      .increment_button(increment_button), .decrement_button(decrement_button),
      .select_button(select_button), .rotary_selector(rotary_selector),
      .excitation_ok(excitation_ok), .display_rdata(display_rdata),
      .port_select_n(port_select_n), .chip_select_n(chip_select_n), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_write(io_write), .io_read(io_read),
      .pair_a_count_enable(pair_a_count_enable), .pair_b_count_enable(pair_b_count_enable));
   display_model partner (.ref_clk(ref_clk), .chip_select_n(chip_select_n),
      .io_addr(io_addr), .io_read(io_read), .display_rdata(display_rdata));
   task automatic tally_and_finish();
      $display("Comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 200);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 200) begin
         errors++;
         tally_and_finish();
      end
      @(posedge ref_clk);
   endtask : bus
   // Counts land on the trailing edge, so the model steps after the low phase
   task automatic pulse(input logic [3:0] m);
      check({7'h00, port_select_n}, 8'h01);
      check(chip_select_n, 8'hFF);
      pulse_in <= m;
      repeat (4) @(posedge ref_clk);
      pulse_in <= 4'h0;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         if (m[i] && !(i < 2 ? pair_a_mode_switch : pair_b_mode_switch)) begin
            cnt[i]++;
         end
      end
   endtask : pulse
   task automatic read_count(input int ch);
      for (int r = 0; r < 3; r++) begin
         bus(1'b0, {1'b0, 3'(4 + ch), 10'h000, 2'(r)}, 8'h00);
         check(rd, 8'(cnt[ch] >> (8 * r)));
      end
   endtask : read_count
   initial begin
      int n;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      repeat (4) begin
         {excitation_ok, rotary_selector, select_button, decrement_button,
            increment_button} <= 8'($random(seed));
         repeat (4) @(posedge ref_clk);
         bus(1'b0, 16'h3000, 8'h00);
         check(rd, {excitation_ok, rotary_selector, select_button, decrement_button,
            increment_button});
         n = $random(seed);
         bus(1'b0, {10'h000, 6'(n)}, 8'h00);
         check(rd, {2'h0, 6'(n)} ^ 8'hA5);
      end
      for (int m = 0; m < 4; m++) begin
         {pair_b_mode_switch, pair_a_mode_switch} <= 2'(m);
         repeat (4) @(posedge ref_clk);
         bus(1'b0, 16'h8000, 8'h00);
         check(rd, {4'h0, 2'(m), 2'h0});
      end
      {pair_b_mode_switch, pair_a_mode_switch} <= 2'h0;
      // Past 4095 so the second stage must step
      repeat (4100) pulse(4'($random(seed)) | 4'h1);
      bus(1'b1, 16'h2000, 8'h00);
      for (int c = 0; c < 4; c++) read_count(c);
      pair_b_mode_switch <= 1'b1;
      bus(1'b1, 16'h1001, 8'h40);
      bus(1'b1, 16'h1002, 8'h01);
      bus(1'b1, 16'h2002, 8'h00);
      cnt[2] = 0;
      cnt[3] = 0;
      repeat (3) pulse(4'hC);
      read_count(2);
      read_count(3);
      bus(1'b1, 16'h2003, 8'h00);
      check({7'h00, pair_b_count_enable}, 8'h01);
      check({7'h00, pair_a_count_enable}, 8'h00);
      repeat (3) pulse(4'hC);
      cnt[2] = 3;
      cnt[3] = 3;
      n = 0;
      while (pair_b_count_enable === 1'b1 && n < 60000) begin
         @(posedge ref_clk);
         n++;
      end
      check({7'h00, pair_b_count_enable}, 8'h00);
      read_count(2);
      read_count(3);
      read_count(0);
      tally_and_finish();
   end
endmodule : pulse_counter_port_logic_bench
